/* File: logic/ddc_ctrl.sv */
// top: command registers, dma request routing, interrupt, sense pin and clock select
`timescale 1ns/10ps
// Summary of operation
// - no irq mode: A from ADC, B to DACs
// - irq mode, no DMA: ADC/timer interrupts
// - one channel feeds DACs, ADC interrupts
// - one channel carries ADC, timer interrupts
// - both channels double-buffer DAC output data, or A to DAC0 / B to DAC1 with both DAC bits set
// - both channels plus ADC: dbuf or split
// - DAC request bits gate DAC requests, except both channels with both bits clear (either DAC)
// - sense bit grounds pin unless nonreferenced single-ended
// - sense bit clear leaves pin undriven
// - field maps codes to levels 3..15
// - clock register upper byte clears on reset
// - clock register lower byte ignores reset
// - clock register write-only at offset 0x06
// - clock select clear: internal clock
// - clock select decodes drive or receive bus
// - channel enable bit gates channel requests
// - ADC request bit gates ADC DMA; DAC modes with irq set still raise ADC interrupts
module ddc_ctrl
    import ddc_pkg::*;
(
    // clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_sys_rst,
    // host bus pins
    input  wire logic                   i_host_wr_n,
    input  wire logic [HOST_ADDR_W-1:0] i_host_addr,
    input  wire logic [HOST_DATA_W-1:0] i_host_data,
    input  wire logic                   i_host_tc,
    // converter events
    input  wire logic                   i_adc_avail,
    input  wire logic                   i_out0_ready,
    input  wire logic                   i_out1_ready,
    input  wire logic                   i_timer_tick,
    input  wire logic                   i_nonreferenced_single_ended,
    // dma and interrupt requests
    output logic                        o_dma_req_a,
    output logic                        o_dma_req_b,
    output logic                        o_adc_irq,
    output logic                        o_timer_irq,
    output logic                        o_irq,
    output logic [3:0]                  o_irq_level,
    // analog sense pin
    output logic                        o_analog_sense_pin_out,
    output logic                        o_analog_sense_pin_oe,
    // board clock selection
    output logic                        o_board_clk_from_sync,
    output logic                        o_sync_clk_drive,
    output logic [CFG_BYTE_W-1:0]       o_clk_cfg_hi,
    output logic [CFG_BYTE_W-1:0]       o_clk_cfg_lo
);
    ddc_host_if host ();
    ddc_route_t route;

    logic [MODE_W-1:0]     mode, next_mode;
    logic [CFG_BYTE_W-1:0] next_cfg_hi, next_cfg_lo;
    logic                  act_b, next_act_b;
    logic                  next_req_a, next_req_b;
    logic                  next_adc_irq, next_timer_irq;
    logic [1:0]            clksel;

    // ==========================================================
    // host pin synchroniser
    ddc_host_port u_port (
        .i_sys_clk   (i_sys_clk),
        .i_sys_rst   (i_sys_rst),
        .i_host_wr_n (i_host_wr_n),
        .i_host_addr (i_host_addr),
        .i_host_data (i_host_data),
        .i_host_tc   (i_host_tc),
        .host        (host.src)
    );

    // ==========================================================
    // mode decode
    ddc_mode_decode u_dec (
        .i_io_int   (mode[IO_INT_BIT]),
        .i_dma_a    (mode[DMA_A_BIT]),
        .i_dma_b    (mode[DMA_B_BIT]),
        .i_conv_req (mode[CONV_REQ_BIT]),
        .i_out_req  ({mode[OUT1_REQ_BIT], mode[OUT0_REQ_BIT]}),
        .o_route    (route)
    );

    // ==========================================================
    // request source per channel route
    function automatic logic src_req(input ddc_src_t src, input logic adc,
                                     input logic rdy0, input logic rdy1);
        case (src)
            SRC_ADC:      return adc;
            SRC_OUT0:     return rdy0;
            SRC_OUT1:     return rdy1;
            SRC_OUT_BOTH: return rdy0 | rdy1;
            default:      return 1'b0;
        endcase
    endfunction

    // ==========================================================
    // command registers
    always_comb begin
        next_mode   = mode;
        next_cfg_hi = o_clk_cfg_hi;
        next_cfg_lo = o_clk_cfg_lo;
        if (host.wr && host.addr == CMD_MODE_OFFSET) begin
            next_mode = host.data[MODE_W-1:0];
        end
        if (host.wr && host.addr == CMD_CLK_OFFSET) begin
            next_cfg_hi = host.data[HOST_DATA_W-1:CFG_BYTE_W];
            next_cfg_lo = host.data[CFG_BYTE_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            mode         <= MODE_RESET;
            o_clk_cfg_hi <= CMD_UPPER_RESET;
        end else begin
            mode         <= next_mode;
            o_clk_cfg_hi <= next_cfg_hi;
        end
    end

    // lower byte keeps its contents across reset
    always_ff @(posedge i_sys_clk) begin
        o_clk_cfg_lo <= next_cfg_lo;
    end

    // ==========================================================
    // dma requests and interrupt sources
    always_comb begin
        logic timer_evt;
        logic adc_evt;
        // conversions only count while the request bit is set or irq mode asks
        adc_evt    = i_adc_avail;
        timer_evt  = route.timer_tick ? i_timer_tick :
                     ((mode[OUT0_REQ_BIT] & i_out0_ready) |
                      (mode[OUT1_REQ_BIT] & i_out1_ready));
        next_act_b = route.dbuf & (act_b ^ host.tc);
        next_req_a = src_req(route.a_src, adc_evt, i_out0_ready, i_out1_ready)
                     & mode[DMA_A_BIT] & ~(route.dbuf & act_b);
        next_req_b = src_req(route.b_src, adc_evt, i_out0_ready, i_out1_ready)
                     & mode[DMA_B_BIT] & ~(route.dbuf & ~act_b);
        next_adc_irq   = route.adc_irq & adc_evt;
        next_timer_irq = route.timer_irq & timer_evt;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            act_b       <= 1'b0;
            o_dma_req_a <= 1'b0;
            o_dma_req_b <= 1'b0;
            o_adc_irq   <= 1'b0;
            o_timer_irq <= 1'b0;
            o_irq       <= 1'b0;
        end else begin
            act_b       <= next_act_b;
            o_dma_req_a <= next_req_a;
            o_dma_req_b <= next_req_b;
            o_adc_irq   <= next_adc_irq;
            o_timer_irq <= next_timer_irq;
            o_irq       <= next_adc_irq | next_timer_irq;
        end
    end

    // ==========================================================
    // irq level, sense pin and clock select
    assign clksel = o_clk_cfg_hi[CLKSEL_HI_LSB +: 2];

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_irq_level            <= ddc_irq_level(MODE_RESET[IRQ_SEL_W-1:0]);
            o_analog_sense_pin_out <= 1'b0;
            o_analog_sense_pin_oe  <= 1'b0;
            o_board_clk_from_sync  <= 1'b0;
            o_sync_clk_drive       <= 1'b0;
        end else begin
            o_irq_level <= ddc_irq_level(mode[IRQ_SEL_LSB +: IRQ_SEL_W]);
            // pin only ever pulled to ground, never driven high
            o_analog_sense_pin_out <= 1'b0;
            o_analog_sense_pin_oe  <= mode[SENSE_DRV_BIT]
                                      & ~i_nonreferenced_single_ended;
            o_board_clk_from_sync  <= (next_cfg_hi[CLKSEL_HI_LSB +: 2]
                                       == CLKSEL_FROM_BUS);
            o_sync_clk_drive       <= (next_cfg_hi[CLKSEL_HI_LSB +: 2]
                                       == CLKSEL_DRIVE_BUS);
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_dbuf_adc_mode;
        mode[IO_INT_BIT] && mode[DMA_A_BIT] && mode[DMA_B_BIT]
        && mode[CONV_REQ_BIT] && !mode[OUT1_REQ_BIT] && !mode[OUT0_REQ_BIT];
    endsequence

    sequence s_swap_to_b;
        (s_dbuf_adc_mode ##0 (!act_b && host.tc && i_adc_avail))
        ##1 (s_dbuf_adc_mode ##0 (i_adc_avail && !host.tc));
    endsequence

    chan_b_out_a: assert property (
        (mode == 10'h1D0 && i_out0_ready) |=> o_dma_req_b)
        else $error("channel B does not request for output 0");

    irq_only_a: assert property (
        (mode[9:6] == 4'h9 && i_adc_avail)
        |=> (o_adc_irq && o_irq && !o_dma_req_a && !o_dma_req_b))
        else $error("ADC interrupt mode wrong");

    single_out_a: assert property (
        (mode[9:4] == 6'h32 && i_out1_ready && i_adc_avail)
        |=> (o_dma_req_a && o_adc_irq && !o_dma_req_b))
        else $error("channel A to output 1 with ADC interrupt wrong");

    adc_chan_a: assert property (
        (mode[9:4] == 6'h2C && i_adc_avail && i_timer_tick)
        |=> (o_dma_req_b && o_timer_irq && !o_adc_irq))
        else $error("channel B from ADC with timer interrupt wrong");

    sync_dual_a: assert property (
        (mode[9:4] == 6'h3B && i_out0_ready && i_out1_ready)
        |=> (o_dma_req_a && o_dma_req_b))
        else $error("sync double channel does not request both");

    dbuf_swap_a: assert property (
        s_swap_to_b |=> (o_dma_req_b && !o_dma_req_a))
        else $error("double buffer did not move to channel B");

    out_gate_a: assert property (
        (!mode[CONV_REQ_BIT] && !mode[OUT1_REQ_BIT] && !mode[OUT0_REQ_BIT]
         && !(mode[DMA_A_BIT] && mode[DMA_B_BIT]))
        |=> (!o_dma_req_a && !o_dma_req_b && !o_timer_irq))
        else $error("request with all request bits clear");

    sense_drive_a: assert property (
        (mode[SENSE_DRV_BIT] && !i_nonreferenced_single_ended)
        |=> (o_analog_sense_pin_oe && !o_analog_sense_pin_out))
        else $error("sense pin not grounded");

    sense_float_a: assert property (
        (!mode[SENSE_DRV_BIT] || i_nonreferenced_single_ended)
        |=> !o_analog_sense_pin_oe)
        else $error("sense pin driven");

    irq_level_a: assert property (
        (mode[2:0] == 3'h4) |=> (o_irq_level == 4'hA))
        else $error("irq level code 4 not level 10");

    upper_clear_a: assert property (
        disable iff (1'b0) i_sys_rst |=> (o_clk_cfg_hi == CMD_UPPER_RESET))
        else $error("upper byte not cleared by reset");

    clk_internal_a: assert property (
        (!clksel[0] && next_cfg_hi == o_clk_cfg_hi)
        |=> (!o_board_clk_from_sync && !o_sync_clk_drive))
        else $error("external clock selected with low select bit clear");

    chan_gate_a: assert property (
        !mode[DMA_A_BIT] |=> !o_dma_req_a)
        else $error("channel A request while disabled");

    unlisted_a: assert property (
        (!mode[IO_INT_BIT] && !mode[DMA_A_BIT] && !mode[DMA_B_BIT])
        |=> (!o_dma_req_a && !o_dma_req_b && !o_irq))
        else $error("request in unlisted mode");

    write_whole_a: assert property (
        (host.wr && host.addr == CMD_MODE_OFFSET)
        |=> (mode == $past(host.data[MODE_W-1:0])))
        else $error("mode write not taken whole");

    clk_write_a: assert property (
        (host.wr && host.addr == CMD_CLK_OFFSET)
        |=> ({o_clk_cfg_hi, o_clk_cfg_lo} == $past(host.data)))
        else $error("clock register write not taken whole");

    clk_from_bus_a: assert property (
        o_board_clk_from_sync == (clksel == CLKSEL_FROM_BUS))
        else $error("board clock source wrong");

    clk_drive_bus_a: assert property (
        o_sync_clk_drive == (clksel == CLKSEL_DRIVE_BUS))
        else $error("sync clock drive wrong");

    timer_irq_a: assert property (
        (mode[9:6] == 4'h8 && mode[OUT0_REQ_BIT] && i_out0_ready)
        |=> (o_timer_irq && o_irq && !o_dma_req_a))
        else $error("timer interrupt mode wrong");

    chan_gate_b_a: assert property (
        !mode[DMA_B_BIT] |=> !o_dma_req_b)
        else $error("channel B request while disabled");

    irq_level_top_a: assert property (
        (mode[2:0] == 3'h7) |=> (o_irq_level == 4'hF))
        else $error("irq level code 7 not level 15");

    chan_a_adc_a: assert property (
        (mode[9:4] == 6'h34 && i_adc_avail && i_timer_tick)
        |=> (o_dma_req_a && o_timer_irq && !o_dma_req_b))
        else $error("channel A from ADC with timer interrupt wrong");

    dbuf_first_a: assert property (
        (mode[9:4] == 6'h39 && i_out0_ready && !act_b)
        |=> (o_dma_req_a && !o_dma_req_b))
        else $error("double buffer channel A not first");
endmodule

/* File: logic/ddc_host_if.sv */
// interface: synchronised host write strobe, address, data and dma terminal count
`timescale 1ns/10ps
interface ddc_host_if;
    import ddc_pkg::*;
    logic                   wr;
    logic [HOST_ADDR_W-1:0] addr;
    logic [HOST_DATA_W-1:0] data;
    logic                   tc;

    modport src (output wr, output addr, output data, output tc);
    modport dst (input wr, input addr, input data, input tc);
endinterface

/* File: logic/ddc_host_port.sv */
// host pin synchroniser: two-stage sync and write / terminal count pulses
`timescale 1ns/10ps
module ddc_host_port
    import ddc_pkg::*;
(
    // clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_sys_rst,
    // host pins
    input  wire logic                   i_host_wr_n,
    input  wire logic [HOST_ADDR_W-1:0] i_host_addr,
    input  wire logic [HOST_DATA_W-1:0] i_host_data,
    input  wire logic                   i_host_tc,
    // synchronised side
    ddc_host_if.src                     host
);
    logic [HOST_ADDR_W-1:0] addr_s1, addr_s2;
    logic [HOST_DATA_W-1:0] data_s1, data_s2;
    logic [2:0]             wr_sh, tc_sh;
    logic [2:0]             next_wr_sh, next_tc_sh;

    // ==========================================================
    // stage shift; strobe active high after inversion
    always_comb begin
        next_wr_sh = {wr_sh[1:0], ~i_host_wr_n};
        next_tc_sh = {tc_sh[1:0], i_host_tc};
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            wr_sh <= 3'h0;
            tc_sh <= 3'h0;
        end else begin
            wr_sh <= next_wr_sh;
            tc_sh <= next_tc_sh;
        end
    end

    // address and data travel with the same two-stage delay as the strobe
    always_ff @(posedge i_sys_clk) begin
        addr_s1 <= i_host_addr;
        addr_s2 <= addr_s1;
        data_s1 <= i_host_data;
        data_s2 <= data_s1;
    end

    // write taken on trailing edge of the strobe, when data is settled
    assign host.wr   = ~wr_sh[1] & wr_sh[2];
    assign host.addr = addr_s2;
    assign host.data = data_s2;
    assign host.tc   = tc_sh[1] & ~tc_sh[2];
endmodule

/* File: logic/ddc_mode_decode.sv */
// mode decoder: maps the enable bits onto channel routing and interrupt sources
`timescale 1ns/10ps
module ddc_mode_decode
    import ddc_pkg::*;
(
    // mode bits
    input  wire logic              i_io_int,
    input  wire logic              i_dma_a,
    input  wire logic              i_dma_b,
    input  wire logic              i_conv_req,
    input  wire logic [1:0]        i_out_req,
    // decoded routing
    output ddc_route_t             o_route
);
    function automatic ddc_src_t out_src(input logic [1:0] req);
        case (req)
            2'h1:    return SRC_OUT0;
            2'h2:    return SRC_OUT1;
            2'h3:    return SRC_OUT_BOTH;
            default: return SRC_NONE;
        endcase
    endfunction

    always_comb begin
        logic     any_out;
        ddc_src_t osrc;
        any_out = |i_out_req;
        osrc    = out_src(i_out_req);
        o_route = '{a_src: SRC_NONE, b_src: SRC_NONE, default: 1'b0};
        // unlisted combinations keep both channels silent
        case ({i_io_int, i_dma_a, i_dma_b})
            3'b010, 3'b110: begin
                if (!i_conv_req && any_out) begin
                    o_route.a_src   = osrc;
                    o_route.adc_irq = i_io_int;
                end else if (i_conv_req && !any_out) begin
                    o_route.a_src      = SRC_ADC;
                    o_route.timer_irq  = i_io_int;
                    o_route.timer_tick = i_io_int;
                end
            end
            3'b001, 3'b101: begin
                if (!i_conv_req && any_out) begin
                    o_route.b_src   = osrc;
                    o_route.adc_irq = i_io_int;
                end else if (i_conv_req && !any_out) begin
                    o_route.b_src      = SRC_ADC;
                    o_route.timer_irq  = i_io_int;
                    o_route.timer_tick = i_io_int;
                end
            end
            3'b011, 3'b111: begin
                if (!i_conv_req) begin
                    o_route.adc_irq = i_io_int;
                    if (i_out_req == 2'h3) begin
                        o_route.a_src = SRC_OUT0;
                        o_route.b_src = SRC_OUT1;
                    end else begin
                        o_route.a_src = any_out ? osrc : SRC_OUT_BOTH;
                        o_route.b_src = o_route.a_src;
                        o_route.dbuf  = 1'b1;
                    end
                end else if (!any_out) begin
                    o_route.a_src      = SRC_ADC;
                    o_route.b_src      = SRC_ADC;
                    o_route.dbuf       = 1'b1;
                    o_route.timer_irq  = i_io_int;
                    o_route.timer_tick = i_io_int;
                end else if (i_io_int) begin
                    o_route.a_src = osrc;
                    o_route.b_src = SRC_ADC;
                end else begin
                    o_route.a_src = SRC_ADC;
                    o_route.b_src = osrc;
                end
            end
            3'b100: begin
                o_route.adc_irq   = i_conv_req;
                o_route.timer_irq = any_out;
            end
            default: o_route.dbuf = 1'b0;
        endcase
    end
endmodule

/* File: logic/ddc_pkg.sv */
// package: offsets, field layout, reset values and types for the dma/irq/clock control block
package ddc_pkg;

    // ==========================================================
    // register offsets (host i/o address, base relative)
    localparam logic [4:0] CMD_MODE_OFFSET = 5'h0A;
    localparam logic [4:0] CMD_CLK_OFFSET  = 5'h06;
    localparam int         HOST_ADDR_W     = 5;
    localparam int         HOST_DATA_W     = 16;

    // ==========================================================
    // mode register field layout
    localparam int         MODE_W         = 10;
    localparam int         IO_INT_BIT     = 9;
    localparam int         DMA_A_BIT      = 8;
    localparam int         DMA_B_BIT      = 7;
    localparam int         CONV_REQ_BIT   = 6;
    localparam int         OUT1_REQ_BIT   = 5;
    localparam int         OUT0_REQ_BIT   = 4;
    localparam int         SENSE_DRV_BIT  = 3;
    localparam int         IRQ_SEL_LSB    = 0;
    localparam int         IRQ_SEL_W      = 3;
    localparam logic [9:0] MODE_RESET     = 10'h000;

    // ==========================================================
    // clock register layout: upper byte cleared by reset, lower byte is not
    localparam int         CFG_BYTE_W       = 8;
    localparam int         CLKSEL_HI_LSB    = 6;
    localparam logic [7:0] CMD_UPPER_RESET  = 8'h00;
    localparam logic [1:0] CLKSEL_DRIVE_BUS = 2'h1;
    localparam logic [1:0] CLKSEL_FROM_BUS  = 2'h3;

    // ==========================================================
    // routing of both dma channels and interrupt sources
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_ADC,
        SRC_OUT0,
        SRC_OUT1,
        SRC_OUT_BOTH
    } ddc_src_t;

    typedef struct packed {
        ddc_src_t a_src;
        ddc_src_t b_src;
        logic     dbuf;
        logic     adc_irq;
        logic     timer_irq;
        logic     timer_tick;
    } ddc_route_t;

    // interrupt level selected by the three-bit channel field
    function automatic logic [3:0] ddc_irq_level(input logic [2:0] sel);
        case (sel)
            3'h0:    return 4'h3;
            3'h1:    return 4'h4;
            3'h2:    return 4'h5;
            3'h3:    return 4'h7;
            3'h4:    return 4'hA;
            3'h5:    return 4'hB;
            3'h6:    return 4'hC;
            default: return 4'hF;
        endcase
    endfunction

endpackage

/* File: tb/ddc_ctrl_tb_top.sv */
// testbench for the dma/irq/clock control block
`timescale 1ns/10ps
module ddc_ctrl_tb_top
    import ddc_pkg::*;
;
    logic                   i_sys_clk = 1'b0;
    logic                   i_sys_rst = 1'b1;
    logic                   wr_n;
    logic [HOST_ADDR_W-1:0] addr;
    logic [HOST_DATA_W-1:0] data;
    logic                   tc;
    logic                   adc_avail = 1'b0;
    logic                   out0_rdy  = 1'b0;
    logic                   out1_rdy  = 1'b0;
    logic                   tick      = 1'b0;
    logic                   nonref_se = 1'b0;
    logic                   dma_a, dma_b, adc_irq, timer_irq, irq, sense_out, sense_oe;
    logic                   from_sync, sync_drive;
    logic [3:0]             irq_level;
    logic [7:0]             cfg_hi, cfg_lo;
    int                     n_errors = 0;
    int                     checked  = 0;
    int                     cycles   = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    ddc_host_model host (.i_sys_clk(i_sys_clk), .o_wr_n(wr_n), .o_addr(addr), .o_data(data),
                         .o_tc(tc));

    ddc_ctrl dut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_host_wr_n(wr_n),
        .i_host_addr(addr), .i_host_data(data), .i_host_tc(tc),
        .i_adc_avail(adc_avail), .i_out0_ready(out0_rdy), .i_out1_ready(out1_rdy),
        .i_timer_tick(tick), .i_nonreferenced_single_ended(nonref_se),
        .o_dma_req_a(dma_a), .o_dma_req_b(dma_b), .o_adc_irq(adc_irq),
        .o_timer_irq(timer_irq), .o_irq(irq), .o_irq_level(irq_level),
        .o_analog_sense_pin_out(sense_out), .o_analog_sense_pin_oe(sense_oe),
        .o_board_clk_from_sync(from_sync), .o_sync_clk_drive(sync_drive),
        .o_clk_cfg_hi(cfg_hi), .o_clk_cfg_lo(cfg_lo));

    // ==========================================================
    // reporting
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic settle();
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask

    // ==========================================================
    // scenarios
    task automatic test_reset_state();
        check("reqs", {11'h000, dma_a, dma_b, adc_irq, timer_irq, irq}, 16'h0000);
        check("clk_hi", {8'h00, cfg_hi}, 16'h0000);
        check("clk_sel", {14'h0000, from_sync, sync_drive}, 16'h0000);
        check("level", {12'h000, irq_level}, 16'h0003);
    endtask

    task automatic test_irq_levels();
        logic [3:0] lv [8];
        lv = '{4'h3, 4'h4, 4'h5, 4'h7, 4'hA, 4'hB, 4'hC, 4'hF};
        for (int i = 0; i < 8; i++) begin
            host.write(CMD_MODE_OFFSET, 16'(i));
            settle();
            check("level", {12'h000, irq_level}, {12'h000, lv[i]});
        end
    endtask

    task automatic test_sense();
        host.write(CMD_MODE_OFFSET, 16'h0008);
        settle();
        check("sense_gnd", {14'h0000, sense_oe, sense_out}, 16'h0002);
        @(posedge i_sys_clk) #1 nonref_se = 1'b1;
        settle();
        check("sense_nonreferenced_single_ended", {15'h0000, sense_oe}, 16'h0000);
        host.write(CMD_MODE_OFFSET, 16'h0000);
        settle();
        check("sense_off_nonreferenced_single_ended", {15'h0000, sense_oe}, 16'h0000);
        @(posedge i_sys_clk) #1 nonref_se = 1'b0;
        settle();
        check("sense_off", {15'h0000, sense_oe}, 16'h0000);
    endtask

    task automatic test_clock_reg();
        host.write(CMD_CLK_OFFSET, 16'h40A5);
        settle();
        check("drive_bus", {14'h0000, from_sync, sync_drive}, 16'h0001);
        host.write(CMD_CLK_OFFSET, 16'h805A);
        settle();
        check("sel_10", {14'h0000, from_sync, sync_drive}, 16'h0000);
        host.write(CMD_CLK_OFFSET, 16'hC03C);
        settle();
        check("from_bus", {14'h0000, from_sync, sync_drive}, 16'h0002);
        check("word", {cfg_hi, cfg_lo}, 16'hC03C);
        host.write(5'h1F, 16'h4011);
        settle();
        check("unmapped", {cfg_hi, cfg_lo}, 16'hC03C);
        @(posedge i_sys_clk) #1 i_sys_rst = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        settle();
        check("rst_word", {cfg_hi, cfg_lo}, 16'h003C);
        check("rst_sel", {14'h0000, from_sync, sync_drive}, 16'h0000);
    endtask

    // events {adc, out0, out1, tick}; outputs {a, b, adc_irq, timer_irq, irq}
    task automatic chk_mode(input logic [9:0] mode, input logic [3:0] ev, input logic [4:0] exp);
        host.write(CMD_MODE_OFFSET, {6'h00, mode});
        @(posedge i_sys_clk) #1 {adc_avail, out0_rdy, out1_rdy, tick} = ev;
        settle();
        check("route", {11'h000, dma_a, dma_b, adc_irq, timer_irq, irq}, {11'h000, exp});
        @(posedge i_sys_clk) #1 {adc_avail, out0_rdy, out1_rdy, tick} = 4'h0;
    endtask

    task automatic test_double_buffer();
        host.write(CMD_MODE_OFFSET, 16'h0390);
        @(posedge i_sys_clk) #1 out0_rdy = 1'b1;
        settle();
        check("dbuf_a", {14'h0000, dma_a, dma_b}, 16'h0002);
        host.tc_pulse();
        check("dbuf_b", {14'h0000, dma_a, dma_b}, 16'h0001);
        host.tc_pulse();
        check("dbuf_a2", {14'h0000, dma_a, dma_b}, 16'h0002);
        @(posedge i_sys_clk) #1 out0_rdy = 1'b0;
    endtask

    initial begin
        repeat (5) @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        settle();
        test_reset_state();
        test_irq_levels();
        test_sense();
        test_clock_reg();
        chk_mode(10'h1D0, 4'h4, 5'h08);
        chk_mode(10'h1D0, 4'h8, 5'h10);
        chk_mode(10'h1D0, 4'h2, 5'h00);
        chk_mode(10'h1E0, 4'h2, 5'h08);
        chk_mode(10'h240, 4'h8, 5'h05);
        chk_mode(10'h210, 4'h4, 5'h03);
        chk_mode(10'h270, 4'hC, 5'h07);
        chk_mode(10'h310, 4'hC, 5'h15);
        chk_mode(10'h2A0, 4'h2, 5'h08);
        chk_mode(10'h340, 4'h9, 5'h13);
        chk_mode(10'h3D0, 4'hC, 5'h18);
        chk_mode(10'h000, 4'hF, 5'h00);
        chk_mode(10'h100, 4'hF, 5'h00);
        chk_mode(10'h110, 4'h4, 5'h10);
        chk_mode(10'h0C0, 4'h8, 5'h08);
        chk_mode(10'h320, 4'hA, 5'h15);
        chk_mode(10'h2C0, 4'h9, 5'h0B);
        chk_mode(10'h3B0, 4'h6, 5'h18);
        chk_mode(10'h3C0, 4'h9, 5'h13);
        test_double_buffer();
        print_verdict();
    end
endmodule

/* File: tb/ddc_host_model.sv */
// host bus model: drives write cycles and dma terminal count pulses
`timescale 1ns/10ps
module ddc_host_model
    import ddc_pkg::*;
(
    // clock
    input  wire logic                   i_sys_clk,
    // host pins
    output logic                        o_wr_n,
    output logic [HOST_ADDR_W-1:0]      o_addr,
    output logic [HOST_DATA_W-1:0]      o_data,
    output logic                        o_tc
);
    initial begin
        o_wr_n = 1'b1;
        o_addr = '0;
        o_data = '0;
        o_tc   = 1'b0;
    end

    // whole 16-bit word, write only, no read cycle exists
    task automatic write(input logic [HOST_ADDR_W-1:0] a, input logic [HOST_DATA_W-1:0] d);
        @(posedge i_sys_clk) #1;
        o_wr_n = 1'b0;
        o_addr = a;
        o_data = d;
        repeat (4) @(posedge i_sys_clk);
        #1 o_wr_n = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        // released lines show the inverse of the last value
        #1 o_addr = ~a;
        o_data = ~d;
        repeat (3) @(posedge i_sys_clk);
    endtask

    task automatic tc_pulse();
        @(posedge i_sys_clk) #1 o_tc = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1 o_tc = 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1;
    endtask
endmodule
